// [bench/dcssm_sensor_model.sv]
// two cam sensors and the guard feedback contact
`timescale 1ns/1ps
module dcssm_sensor_model (
  input wire logic clk,
  output logic     pulse_one,
  output logic     pulse_two,
  output logic     fb_a,
  output logic     fb_b
);
  logic stuck_two;
  logic fb_open;
  assign fb_a = !fb_open;
  assign fb_b = !fb_open;
  initial begin
    pulse_one = 1'b1;
    pulse_two = 1'b1;
    stuck_two = 1'b0;
    fb_open = 1'b0;
  end
  // cams three quarters long, half a turn apart: one sensor always damped
  task automatic spin(input int revs, input int per);
    int ph;
    for (int i = 0; i < revs * per; i++) begin
      @(posedge clk);
      #1;
      ph = (i + 1) % per;
      pulse_one = ph < per * 3 / 4;
      pulse_two = stuck_two | (((ph + per / 2) % per) < per * 3 / 4);
    end
  endtask
  // broken cam layout: both sensors face a gap
  task automatic gap(input int cyc);
    @(posedge clk);
    #1;
    pulse_one = 1'b0;
    pulse_two = 1'b0;
    repeat (cyc) @(posedge clk);
    #1;
    pulse_one = 1'b1;
    pulse_two = 1'b1;
  endtask
endmodule

// [bench/dcssm_top_chk.sv]
// port assertions of the standstill monitor top
`timescale 1ns/1ps
module dcssm_top_chk
  import dcssm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = 10,
  parameter int unsigned SELFTEST_MS_P = 5
)
(
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       pulse_in_one,
  input wire logic       pulse_in_two,
  input wire logic       feedback_in_a,
  input wire logic       feedback_in_b,
  input wire logic       relay_channel_one,
  input wire logic       relay_channel_two,
  input wire logic       switch_closed,
  input wire logic       input_indicator_one,
  input wire logic       input_indicator_two,
  input wire logic       relay_indicator_one,
  input wire logic       fault_indicator,
  input wire logic       power_indicator,
  input wire logic       fault_status_out,
  input wire logic       selftest_busy,
  input wire logic [2:0] fault_cause
);
  // a few cycles of slack for tick phase and output registers
  localparam int ST_LIM = (SELFTEST_MS_P + 1) * TICK_CYCLES_P + 6;
  localparam int LOW_LIM = (int'(BOTH_LOW_GRACE_MS) + 2) * TICK_CYCLES_P + 4;
  localparam int LED_LIM = (int'(BLINK_HALF_MS) + 2) * TICK_CYCLES_P + 4;
  logic [19:0] busy_cnt_r;
  logic [19:0] busy_cnt_nxt;
  logic [19:0] low_cnt_r;
  logic [19:0] low_cnt_nxt;
  logic [19:0] hold_cnt_r;
  logic [19:0] hold_cnt_nxt;
  logic        led_r;
  logic        fb_closed;
  assign fb_closed = feedback_in_a && feedback_in_b;
  always_comb begin
    busy_cnt_nxt = selftest_busy ? busy_cnt_r + 20'h0_0001 : 20'h0_0000;
    low_cnt_nxt = (!selftest_busy && !pulse_in_one && !pulse_in_two) ?
                  low_cnt_r + 20'h0_0001 : 20'h0_0000;
    hold_cnt_nxt = (!selftest_busy && !fb_closed && fault_cause == 3'h0 &&
                    relay_indicator_one == led_r) ?
                   hold_cnt_r + 20'h0_0001 : 20'h0_0000;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt_r <= 20'h0_0000;
      low_cnt_r <= 20'h0_0000;
      hold_cnt_r <= 20'h0_0000;
      led_r <= 1'b0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
      low_cnt_r <= low_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      led_r <= relay_indicator_one;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_fault_safe;
    $past(|fault_cause) |-> !relay_channel_one && !relay_channel_two &&
                            !switch_closed;
  endproperty
  a_fault_safe: assert property (p_fault_safe)
    else $error("relay energised with a fault latched");
  property p_fault_flag;
    fault_cause != 3'h0 |-> ##[0:2] (!fault_status_out && fault_indicator);
  endproperty
  a_fault_flag: assert property (p_fault_flag)
    else $error("fault not shown on status and indicator");
  property p_no_fault;
    fault_cause == 3'h0 |-> fault_status_out;
  endproperty
  a_no_fault: assert property (p_no_fault)
    else $error("status low without a fault");
  property p_latch;
    fault_cause != 3'h0 |=>
      (fault_cause & $past(fault_cause)) == $past(fault_cause);
  endproperty
  a_latch: assert property (p_latch)
    else $error("fault cause cleared without reset");
  property p_series;
    switch_closed |-> (relay_channel_one && relay_channel_two) ||
                      ($past(relay_channel_one) && $past(relay_channel_two));
  endproperty
  a_series: assert property (p_series)
    else $error("switch closed without both relays");
  property p_selftest_safe;
    selftest_busy |-> !relay_channel_one && !relay_channel_two;
  endproperty
  a_selftest_safe: assert property (p_selftest_safe)
    else $error("relay energised during self test");
  property p_selftest_len;
    int'(busy_cnt_r) <= ST_LIM;
  endproperty
  a_selftest_len: assert property (p_selftest_len)
    else $error("self test too long");
  property p_fb_open;
    !fb_closed [*3] |-> !relay_channel_one && !relay_channel_two;
  endproperty
  a_fb_open: assert property (p_fb_open)
    else $error("relay energised with feedback open");
  property p_input_led;
    $past(power_indicator, 2) |-> input_indicator_one == $past(pulse_in_one)
      && input_indicator_two == $past(pulse_in_two);
  endproperty
  a_input_led: assert property (p_input_led)
    else $error("input indicator does not follow its sensor");
  property p_both_low;
    int'(low_cnt_r) == LOW_LIM |-> fault_cause != 3'h0;
  endproperty
  a_both_low: assert property (p_both_low)
    else $error("both sensors low without a fault");
  property p_blink;
    int'(hold_cnt_r) <= LED_LIM;
  endproperty
  a_blink: assert property (p_blink)
    else $error("relay indicator not flashing with feedback open");
endmodule

bind dcssm_top dcssm_top_chk #(.TICK_CYCLES_P(TICK_CYCLES_P),
  .SELFTEST_MS_P(SELFTEST_MS_P)) u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .pulse_in_one(pulse_in_one), .pulse_in_two(pulse_in_two),
  .feedback_in_a(feedback_in_a), .feedback_in_b(feedback_in_b),
  .relay_channel_one(relay_channel_one),
  .relay_channel_two(relay_channel_two), .switch_closed(switch_closed),
  .input_indicator_one(input_indicator_one),
  .input_indicator_two(input_indicator_two),
  .relay_indicator_one(relay_indicator_one),
  .fault_indicator(fault_indicator), .power_indicator(power_indicator),
  .fault_status_out(fault_status_out), .selftest_busy(selftest_busy),
  .fault_cause(fault_cause));

// [bench/dcssm_top_test.sv]
// self-checking bench of the dual channel standstill monitor
`timescale 1ns/1ps
module dcssm_top_test;
  import dcssm_pkg::*;
  localparam int TK = 4;
  localparam int ST = 5;
  localparam int FAST = 400;
  localparam int LIMIT = 90000;
  logic       sys_clk;
  logic       arst_n;
  logic       strap_a;
  logic       strap_b;
  wire logic  pin_one, pin_two, fb_a, fb_b;
  wire logic  rl1, rl2, sw, ii1, ii2, ri1, fi, pwr, st_out, sa, sb, busy;
  wire logic [2:0] cause;
  wire logic  ri2;
  wire dcssm_ms_type f1, f2;
  int         fails = 0;
  int         check_count = 0;
  int         cycles = 0;

  dcssm_sensor_model u_sens (.clk(sys_clk), .pulse_one(pin_one),
    .pulse_two(pin_two), .fb_a(fb_a), .fb_b(fb_b));
  dcssm_top #(.TICK_CYCLES_P(TK), .SELFTEST_MS_P(ST)) uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .pulse_in_one(pin_one),
    .pulse_in_two(pin_two), .point_strap_a(strap_a),
    .point_strap_b(strap_b), .feedback_in_a(fb_a), .feedback_in_b(fb_b),
    .relay_channel_one(rl1), .relay_channel_two(rl2), .switch_closed(sw),
    .input_indicator_one(ii1), .input_indicator_two(ii2),
    .relay_indicator_one(ri1), .relay_indicator_two(ri2),
    .fault_indicator(fi), .power_indicator(pwr),
    .fault_status_out(st_out), .sensor_supply_a(sa), .sensor_supply_b(sb),
    .selftest_busy(busy), .fault_cause(cause), .freq_channel_one(f1),
    .freq_channel_two(f2));

  always #2.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // energise period in ms ticks, 5 % under the switch point
  function automatic int on_ticks(input int sel);
    int chz;
    chz = (sel == 0) ? 20 : (sel == 1) ? 50 : (sel == 2) ? 100 : 200;
    return 10000000 / (95 * chz);
  endfunction

  task automatic do_reset(input int sel);
    int n;
    arst_n = 1'b0;
    strap_a = sel[0];
    strap_b = sel[1];
    u_sens.stuck_two = 1'b0;
    u_sens.fb_open = 1'b0;
    tick(10);
    check("status in reset", st_out, 1);
    check("relays in reset", {rl1, rl2, sw}, 0);
    arst_n = 1'b1;
    n = 0;
    while (busy !== 1'b0 && n < 2 * ST * TK + 20) begin
      tick(1);
      n++;
    end
    check("selftest length", n >= ST * TK, 1);
    check("busy after selftest", busy, 0);
    check("sensor supply", {sa, sb, pwr}, 3'h7);
  endtask

  task automatic t_standstill(input int sel);
    do_reset(sel);
    u_sens.spin(2, FAST);
    tick(TK * (on_ticks(sel) - 5));
    check("relay early", rl1, 0);
    tick(TK * 12);
    check("relays", {rl1, rl2, sw}, 3'h7);
    check("relay led", {ri1, ri2}, 2'h3);
    check("status", {st_out, fi}, 2'h2);
  endtask

  task automatic t_motion();
    int n;
    int n2;
    logic ind;
    logic ind2;
    u_sens.spin(2, FAST);
    check("relays moving", {rl1, rl2, sw}, 3'h0);
    check("no fault moving", cause, 3'h0);
    // a tick on the edge of a rise is lost, so one short is fine
    tick(1);
    check("period one", f1 == FAST / TK || f1 == FAST / TK - 1, 1);
    check("period two", f2 == FAST / TK || f2 == FAST / TK - 1, 1);
    u_sens.fb_open = 1'b1;
    tick(TK * (on_ticks(3) + 12));
    check("relays fb open", {rl1, rl2, sw}, 3'h0);
    check("status fb open", {st_out, fi}, 2'h2);
    n = 0;
    n2 = 0;
    repeat (TK * 1100) begin
      ind = ri1;
      ind2 = ri2;
      tick(1);
      if (ri1 !== ind)
        n++;
      if (ri2 !== ind2)
        n2++;
    end
    check("led flashes", n >= 2, 1);
    check("led two flashes", n2 >= 2, 1);
    u_sens.fb_open = 1'b0;
    tick(8);
    check("relays fb closed", {rl1, rl2, sw}, 3'h7);
  endtask

  task automatic t_mismatch();
    do_reset(3);
    tick(TK * (on_ticks(3) + 12));
    u_sens.stuck_two = 1'b1;
    u_sens.spin(3, FAST);
    check("mismatch cause", cause, 3'h1);
    check("relays mismatch", {rl1, rl2, sw}, 3'h0);
    check("fault outputs", {st_out, fi}, 2'h1);
    u_sens.stuck_two = 1'b0;
    // matching pulses then standstill must not re-arm the relays
    u_sens.spin(2, FAST);
    tick(TK * (on_ticks(3) + 12));
    check("latched", {rl1, st_out, cause}, 5'h01);
  endtask

  task automatic t_faults();
    do_reset(3);
    check("cause cleared", cause, 3'h0);
    u_sens.gap(TK * 30);
    check("both low cause", cause, 3'h2);
    check("both low outputs", {rl1, st_out, fi}, 3'h1);
    do_reset(2);
    strap_a = 1'b1;
    tick(4);
    check("strap cause", cause, 3'h4);
    check("strap status", st_out, 0);
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    strap_a = 1'b0;
    strap_b = 1'b0;
    for (int s = 0; s < 4; s++)
      t_standstill(s);
    t_motion();
    t_mismatch();
    t_faults();
    end_of_test();
  end
endmodule

// [hw/dcssm_chan.sv]
// one pulse channel: edge detect, period measure, underspeed hysteresis
`timescale 1ns/1ps
module dcssm_chan
  import dcssm_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         pulse_in,
  input  wire dcssm_ms_type on_ms,
  input  wire dcssm_ms_type off_ms,
  output logic              rise,
  output dcssm_ms_type      period_r,
  output logic              slow_r
);

  logic         prev_r;
  dcssm_ms_type since_r;
  logic         prev_nxt;
  dcssm_ms_type since_nxt;
  dcssm_ms_type period_nxt;
  logic         slow_nxt;

  assign rise = pulse_in & ~prev_r;

  always_comb begin
    prev_nxt   = pulse_in;
    since_nxt  = since_r;
    period_nxt = period_r;
    slow_nxt   = slow_r;
    if (rise) begin
      since_nxt  = '0;
      period_nxt = since_r;
      if (since_r < off_ms) begin
        slow_nxt = 1'b0;
      end else if (since_r > on_ms) begin
        slow_nxt = 1'b1;
      end
    end else begin
      if (tick && since_r != MS_MAX) begin
        since_nxt = since_r + 1'b1;
      end
      // no edge for longer than the energise period is slow already
      if (since_r > on_ms) begin
        slow_nxt = 1'b1;
        period_nxt = since_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r   <= 1'b0;
      since_r  <= '0;
      period_r <= '0;
      slow_r   <= 1'b0;
    end else begin
      prev_r   <= prev_nxt;
      since_r  <= since_nxt;
      period_r <= period_nxt;
      slow_r   <= slow_nxt;
    end
  end

endmodule

// [hw/dcssm_top.sv]
// dual channel standstill monitor: sequencing, checks, relays, indicators
`timescale 1ns/1ps
module dcssm_top
  import dcssm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
  parameter int unsigned SELFTEST_MS_P = SELFTEST_MS
)
(
  input  wire logic   sys_clk,
  input  wire logic   arst_n,
  input  wire logic   pulse_in_one,
  input  wire logic   pulse_in_two,
  input  wire logic   point_strap_a,
  input  wire logic   point_strap_b,
  input  wire logic   feedback_in_a,
  input  wire logic   feedback_in_b,
  output logic        relay_channel_one,
  output logic        relay_channel_two,
  output logic        switch_closed,
  output logic        input_indicator_one,
  output logic        input_indicator_two,
  output logic        relay_indicator_one,
  output logic        relay_indicator_two,
  output logic        fault_indicator,
  output logic        power_indicator,
  output logic        fault_status_out,
  output logic        sensor_supply_a,
  output logic        sensor_supply_b,
  output logic        selftest_busy,
  output logic [2:0]  fault_cause,
  output dcssm_ms_type freq_channel_one,
  output dcssm_ms_type freq_channel_two
);

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // 1 ms timebase
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_cnt_nxt;
  logic              tick_r;
  logic              tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 1'b1;
    if (tick_cnt_r == TICK_W'(TICK_CYCLES_P - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // strap capture after reset release, then watched for changes
  logic [1:0] strap_now;
  logic [1:0] strap_cap_r;
  logic       strap_ok_r;
  logic [1:0] strap_cap_nxt;
  logic       strap_ok_nxt;
  logic       strap_changed;

  assign strap_now = {point_strap_b, point_strap_a};

  always_comb begin
    strap_cap_nxt = strap_cap_r;
    strap_ok_nxt  = 1'b1;
    if (!strap_ok_r) begin
      strap_cap_nxt = strap_now;
    end
  end

  assign strap_changed = strap_ok_r && (strap_now != strap_cap_r);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cap_r <= SEL_0P2;
      strap_ok_r  <= 1'b0;
    end else begin
      strap_cap_r <= strap_cap_nxt;
      strap_ok_r  <= strap_ok_nxt;
    end
  end

  // thresholds from the captured switch point
  dcssm_ms_type on_ms;
  dcssm_ms_type off_ms;

  assign on_ms  = dcssm_on_ms(strap_cap_r);
  assign off_ms = dcssm_off_ms(strap_cap_r);

  logic rise_one;
  logic rise_two;
  logic slow_one;
  logic slow_two;

  dcssm_chan u_chan_one (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .tick     (tick_r),
    .pulse_in (pulse_in_one),
    .on_ms    (on_ms),
    .off_ms   (off_ms),
    .rise     (rise_one),
    .period_r (freq_channel_one),
    .slow_r   (slow_one)
  );

  dcssm_chan u_chan_two (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .tick     (tick_r),
    .pulse_in (pulse_in_two),
    .on_ms    (on_ms),
    .off_ms   (off_ms),
    .rise     (rise_two),
    .period_r (freq_channel_two),
    .slow_r   (slow_two)
  );

  // sequencer, pulse comparison and both-low watch
  dcssm_state_type state_r;
  dcssm_state_type state_nxt;
  dcssm_ms_type    st_cnt_r;
  dcssm_ms_type    st_cnt_nxt;
  logic [2:0]      diff_r;
  logic [2:0]      diff_nxt;
  logic [2:0]      diff_mag;
  dcssm_ms_type    low_cnt_r;
  dcssm_ms_type    low_cnt_nxt;
  logic [FLT_W-1:0] fault_r;
  logic [FLT_W-1:0] fault_nxt;
  logic [FLT_W-1:0] fault_new;
  logic            both_low;

  assign both_low = ~pulse_in_one & ~pulse_in_two;
  assign diff_mag = diff_r[2] ? (3'h0 - diff_r) : diff_r;

  always_comb begin
    state_nxt   = state_r;
    st_cnt_nxt  = st_cnt_r;
    diff_nxt    = diff_r;
    low_cnt_nxt = low_cnt_r;
    fault_new   = '0;
    fault_nxt   = fault_r;
    unique case (state_r)
      ST_SELFTEST: begin
        diff_nxt    = '0;
        low_cnt_nxt = '0;
        if (tick_r) begin
          st_cnt_nxt = st_cnt_r + 1'b1;
        end
        if (st_cnt_r >= MS_W'(SELFTEST_MS_P)) begin
          state_nxt = ST_RUN;
        end
        if (strap_changed) begin
          fault_new[FLT_STRAP] = 1'b1;
        end
      end
      ST_RUN: begin
        // one sensor may lead by one pulse; more means a lost channel
        if (rise_one && !rise_two) begin
          diff_nxt = diff_r + 1'b1;
        end else if (rise_two && !rise_one) begin
          diff_nxt = diff_r - 1'b1;
        end
        if (diff_mag >= DIFF_LIMIT) begin
          fault_new[FLT_MISMATCH] = 1'b1;
        end
        // short grace covers sensor switching skew at cam edges
        if (!both_low) begin
          low_cnt_nxt = '0;
        end else if (tick_r && low_cnt_r != MS_MAX) begin
          low_cnt_nxt = low_cnt_r + 1'b1;
        end
        if (low_cnt_r >= BOTH_LOW_GRACE_MS) begin
          fault_new[FLT_BOTH_LOW] = 1'b1;
        end
        if (strap_changed) begin
          fault_new[FLT_STRAP] = 1'b1;
        end
      end
      ST_FAULT: begin
        // only arst_n leaves this state
        state_nxt = ST_FAULT;
      end
      default: begin
        state_nxt = ST_FAULT;
      end
    endcase
    fault_nxt = fault_r | fault_new;
    if (fault_new != '0) begin
      state_nxt = ST_FAULT;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_SELFTEST;
      st_cnt_r  <= '0;
      diff_r    <= '0;
      low_cnt_r <= '0;
      fault_r   <= '0;
    end else begin
      state_r   <= state_nxt;
      st_cnt_r  <= st_cnt_nxt;
      diff_r    <= diff_nxt;
      low_cnt_r <= low_cnt_nxt;
      fault_r   <= fault_nxt;
    end
  end

  // blink for the relay indicators while the guard is open
  dcssm_ms_type blink_cnt_r;
  dcssm_ms_type blink_cnt_nxt;
  logic         blink_r;
  logic         blink_nxt;

  always_comb begin
    blink_cnt_nxt = blink_cnt_r;
    blink_nxt     = blink_r;
    if (tick_r) begin
      if (blink_cnt_r >= BLINK_HALF_MS - 1'b1) begin
        blink_cnt_nxt = '0;
        blink_nxt     = ~blink_r;
      end else begin
        blink_cnt_nxt = blink_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
    end else begin
      blink_cnt_r <= blink_cnt_nxt;
      blink_r     <= blink_nxt;
    end
  end

  // relays and indicators, all registered
  logic feedback_closed;
  logic run_ok;
  logic relay_one_nxt;
  logic relay_two_nxt;
  logic closed_nxt;
  logic rled_one_nxt;
  logic rled_two_nxt;
  logic fled_nxt;
  logic status_nxt;
  logic in_one_nxt;
  logic in_two_nxt;

  assign feedback_closed = feedback_in_a & feedback_in_b;
  assign run_ok = (state_r == ST_RUN) && (fault_nxt == '0);

  always_comb begin
    // a channel running fast releases both, contacts are in series
    relay_one_nxt = run_ok && slow_one && slow_two
                    && feedback_closed;
    relay_two_nxt = relay_one_nxt;
    closed_nxt = relay_one_nxt & relay_two_nxt;
    rled_one_nxt = 1'b0;
    rled_two_nxt = 1'b0;
    if (state_r == ST_RUN) begin
      if (!feedback_closed) begin
        rled_one_nxt = blink_r;
        rled_two_nxt = blink_r;
      end else begin
        rled_one_nxt = relay_one_nxt;
        rled_two_nxt = relay_two_nxt;
      end
    end
    fled_nxt   = (state_nxt == ST_FAULT);
    status_nxt = (state_nxt != ST_FAULT);
    in_one_nxt = pulse_in_one;
    in_two_nxt = pulse_in_two;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_channel_one   <= 1'b0;
      relay_channel_two   <= 1'b0;
      switch_closed       <= 1'b0;
      relay_indicator_one <= 1'b0;
      relay_indicator_two <= 1'b0;
      fault_indicator     <= 1'b0;
      fault_status_out    <= 1'b1;
      input_indicator_one <= 1'b0;
      input_indicator_two <= 1'b0;
      power_indicator     <= 1'b0;
      sensor_supply_a     <= 1'b0;
      sensor_supply_b     <= 1'b0;
    end else begin
      relay_channel_one   <= relay_one_nxt;
      relay_channel_two   <= relay_two_nxt;
      switch_closed       <= closed_nxt;
      relay_indicator_one <= rled_one_nxt;
      relay_indicator_two <= rled_two_nxt;
      fault_indicator     <= fled_nxt;
      fault_status_out    <= status_nxt;
      input_indicator_one <= in_one_nxt;
      input_indicator_two <= in_two_nxt;
      power_indicator     <= 1'b1;
      sensor_supply_a     <= 1'b1;
      sensor_supply_b     <= 1'b1;
    end
  end

  assign selftest_busy = (state_r == ST_SELFTEST);
  assign fault_cause   = fault_r;

endmodule

// [shared/dcssm_pkg.sv]
// constants, types and decode functions of the dual channel standstill monitor
package dcssm_pkg;

  localparam int unsigned CLK_PERIOD_PS = 5_000;
  localparam int unsigned TICK_PERIOD_PS = 1_000_000_000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int unsigned TICK_W = 18;

  localparam int unsigned SELFTEST_S = 6;
  localparam int unsigned SELFTEST_MS = SELFTEST_S * 1000;

  localparam int unsigned MS_W = 14;
  localparam logic [13:0] MS_MAX = 14'h3fff;

  // switch points in hundredths of a hertz
  localparam int unsigned SP_0P2_CHZ = 20;
  localparam int unsigned SP_0P5_CHZ = 50;
  localparam int unsigned SP_1P0_CHZ = 100;
  localparam int unsigned SP_2P0_CHZ = 200;
  localparam int unsigned HYST_LO_PCT = 95;
  localparam int unsigned HYST_HI_PCT = 105;
  // ms per second times centi-hertz scale times percent scale
  localparam int unsigned PERIOD_SCALE = 1000 * 100 * 100;

  localparam logic [1:0] SEL_0P2 = 2'h0;
  localparam logic [1:0] SEL_0P5 = 2'h1;
  localparam logic [1:0] SEL_1P0 = 2'h2;
  localparam logic [1:0] SEL_2P0 = 2'h3;

  localparam logic [13:0] BOTH_LOW_GRACE_MS = 14'h0014;
  localparam logic [13:0] BLINK_HALF_MS = 14'h00fa;
  localparam logic [2:0] DIFF_LIMIT = 3'h2;

  localparam int unsigned FLT_MISMATCH = 0;
  localparam int unsigned FLT_BOTH_LOW = 1;
  localparam int unsigned FLT_STRAP = 2;
  localparam int unsigned FLT_W = 3;

  typedef logic [MS_W-1:0] dcssm_ms_type;

  typedef enum logic [2:0] {
    ST_SELFTEST = 3'h1,
    ST_RUN      = 3'h2,
    ST_FAULT    = 3'h4
  } dcssm_state_type;

  function automatic int unsigned dcssm_sp_chz(input logic [1:0] sel);
    unique case (sel)
      SEL_0P2: dcssm_sp_chz = SP_0P2_CHZ;
      SEL_0P5: dcssm_sp_chz = SP_0P5_CHZ;
      SEL_1P0: dcssm_sp_chz = SP_1P0_CHZ;
      SEL_2P0: dcssm_sp_chz = SP_2P0_CHZ;
    endcase
  endfunction

  // period above which the shaft is slow enough to energise
  function automatic dcssm_ms_type dcssm_on_ms(input logic [1:0] sel);
    dcssm_on_ms = MS_W'(PERIOD_SCALE / (HYST_LO_PCT * dcssm_sp_chz(sel)));
  endfunction

  // period below which the shaft is too fast and relays release
  function automatic dcssm_ms_type dcssm_off_ms(input logic [1:0] sel);
    dcssm_off_ms = MS_W'(PERIOD_SCALE / (HYST_HI_PCT * dcssm_sp_chz(sel)));
  endfunction

endpackage
